// ### src/exc_prio_cfg.svh
// Constants for the exception priority and vector lookup block
`ifndef EXC_PRIO_CFG_SVH
`define EXC_PRIO_CFG_SVH

`define EXC_NUM_W        6
`define PRIO_W           3
`define LEVEL_W          4
`define IRQ_COUNT        30
`define IRQ_FIRST_EXC    6'h10
`define EXC_RESET        6'h01
`define EXC_NMI          6'h02
`define EXC_HARDFAULT    6'h03
`define EXC_MEMFAULT     6'h04
`define EXC_BUSFAULT     6'h05
`define EXC_USAGEFAULT   6'h06
`define EXC_SVCALL       6'h0B
`define EXC_DEBUGMON     6'h0C
`define EXC_PEND_SERVICE 6'h0E
`define EXC_SYSTICK      6'h0F
`define EXC_NONE         6'h00
`define OFS_STACK_TOP    32'h0000_0000
`define OFS_PEND_SERVICE 32'h0000_0038
`define OFS_SYSTICK      32'h0000_003C
`define OFS_IRQ_BASE     32'h0000_0040
`define VTOR_RESET       32'h0000_0000
`define VTOR_MIN         32'h0000_0100
`define VTOR_MAX         32'h3FFF_FF00
`define VTOR_ALIGN_MASK  32'h0000_00FF
`define IRQ_RSVD_MASK    30'h0003_C200
`define PRIO_RESET       3'h0
`define LVL_RESET        4'h0
`define LVL_NMI          4'h1
`define LVL_HARDFAULT    4'h2
`define LVL_CFG_OFS      4'h3
`define LVL_IDLE         4'hF

`endif

// ### src/exc_prio_pkg.sv
// Types for the exception priority and vector lookup block
package exc_prio_pkg;
    typedef enum logic [2:0] {
        ST_FETCH_SP = 3'h1,
        ST_FETCH_RV = 3'h2,
        ST_RUN      = 3'h4
    } boot_state_type;
endpackage

// ### src/exception_priority_vector.sv
// Exception prioritisation, preemption decision and vector address lookup
// Notes on behaviour
// - Pend service 0x38, tick 0x3C, IRQs from 0x40
// - IRQ n is exception n+16; 9,14-17 reserved
// - Configurable priorities reset to zero
// - Reset forces vector base to zero
// - Relocated base must be 0x100..0x3FFFFF00
// - Smaller priority value is more urgent
// - Reset, NMI, hard fault priorities fixed
// - Configurable levels 0-7, below fixed ones
// - Ties go to smallest exception number
// - Strictly more urgent exception preempts handler
// - Equal priority stays pending, no preemption
// - NMI always enabled, level -2, unmaskable
// - Hard fault -1, reset -3
// - Stack pointer fetched from offset zero first
`timescale 1ns/10ps
`default_nettype none
`include "exc_prio_cfg.svh"

module exception_priority_vector
(
    // Clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     arst_n,
    // Exception and interrupt requests
    input  wire logic                     nmi_req,
    input  wire logic                     hardfault_req,
    input  wire logic                     memfault_req,
    input  wire logic                     busfault_req,
    input  wire logic                     usagefault_req,
    input  wire logic                     svcall_req,
    input  wire logic                     debugmon_req,
    input  wire logic                     pendable_service_request,
    input  wire logic                     systick_req,
    input  wire logic [`IRQ_COUNT-1:0]    irq_req,
    input  wire logic [`IRQ_COUNT-1:0]    irq_enable,
    // Priority configuration
    input  wire logic [3*`IRQ_COUNT-1:0]  irq_priority_regs,
    input  wire logic [3*7-1:0]           system_handler_priority_reg,
    input  wire logic                     priority_write,
    // Vector table relocation
    input  wire logic [31:0]              vector_base_offset_reg,
    input  wire logic                     vector_base_write,
    input  wire logic                     privileged,
    // Core handshake
    input  wire logic                     boot_fetch_done,
    input  wire logic                     exc_taken,
    input  wire logic                     exc_return,
    // Results
    output logic                          boot_fetch_valid,
    output logic [31:0]                   boot_fetch_addr,
    output logic                          exc_valid,
    output logic                          exc_preempt,
    output logic [`EXC_NUM_W-1:0]         exc_number,
    output logic [31:0]                   exc_vector_addr,
    output logic [`EXC_NUM_W-1:0]         active_number,
    output logic [31:0]                   vector_base,
    output logic                          vector_base_reject
);

    // ------------------------------------------------------------
    // Priority storage
    // ------------------------------------------------------------
    logic [`PRIO_W-1:0] irq_prio [`IRQ_COUNT];
    logic [`PRIO_W-1:0] sys_prio [7];
    logic [`LEVEL_W-1:0] active_level;
    exc_prio_pkg::boot_state_type boot_state;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Exception number of system slot k: mem,bus,usage,svc,dbg,pend,tick
    function automatic logic [`EXC_NUM_W-1:0] sys_slot_num(input int k);
        case (k)
            0: sys_slot_num = `EXC_MEMFAULT;
            1: sys_slot_num = `EXC_BUSFAULT;
            2: sys_slot_num = `EXC_USAGEFAULT;
            3: sys_slot_num = `EXC_SVCALL;
            4: sys_slot_num = `EXC_DEBUGMON;
            5: sys_slot_num = `EXC_PEND_SERVICE;
            default: sys_slot_num = `EXC_SYSTICK;
        endcase
    endfunction

    // Configurable value 0-7 maps to levels above the fixed ones
    function automatic logic [`LEVEL_W-1:0] cfg_level(input logic [`PRIO_W-1:0] p);
        cfg_level = {1'b0, p} + `LVL_CFG_OFS;
    endfunction

    // Base plus four times exception number
    function automatic logic [31:0] vec_addr(input logic [31:0] base,
                                             input logic [`EXC_NUM_W-1:0] n);
        vec_addr = base + {24'h00_0000, n, 2'b00};
    endfunction

    // ------------------------------------------------------------
    // Priority capture
    // ------------------------------------------------------------
    // All levels load together so no half-written set is ever arbitrated
    genvar gi;
    generate
        for (gi = 0; gi < `IRQ_COUNT; gi++)
        begin : g_irq_prio
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                    irq_prio[gi] <= `PRIO_RESET;
                else if (priority_write)
                    irq_prio[gi] <= irq_priority_regs[`PRIO_W*gi +: `PRIO_W];
            end
        end
        for (gi = 0; gi < 7; gi++)
        begin : g_sys_prio
            always_ff @(posedge core_clk or negedge arst_n)
            begin
                if (!arst_n)
                    sys_prio[gi] <= `PRIO_RESET;
                else if (priority_write)
                    sys_prio[gi] <= system_handler_priority_reg[`PRIO_W*gi +: `PRIO_W];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    logic [`LEVEL_W-1:0]   best_level;
    logic [`EXC_NUM_W-1:0] best_num;
    logic [6:0]            sys_req;
    logic [`IRQ_COUNT-1:0] irq_live;

    assign sys_req = {systick_req, pendable_service_request, debugmon_req, svcall_req,
                      usagefault_req, busfault_req, memfault_req};
    // Reserved numbers have no source; masked so a stray line cannot win
    assign irq_live = irq_req & irq_enable & ~`IRQ_RSVD_MASK;

    // Scan in ascending number; strict compare keeps the lower number on ties
    always_comb
    begin
        best_level = `LVL_IDLE;
        best_num   = `EXC_NONE;
        if (nmi_req)
        begin
            best_level = `LVL_NMI;
            best_num   = `EXC_NMI;
        end
        if (hardfault_req && `LVL_HARDFAULT < best_level)
        begin
            best_level = `LVL_HARDFAULT;
            best_num   = `EXC_HARDFAULT;
        end
        for (int k = 0; k < 7; k++)
        begin
            if (sys_req[k] && cfg_level(sys_prio[k]) < best_level)
            begin
                best_level = cfg_level(sys_prio[k]);
                best_num   = sys_slot_num(k);
            end
        end
        for (int k = 0; k < `IRQ_COUNT; k++)
        begin
            if (irq_live[k] && cfg_level(irq_prio[k]) < best_level)
            begin
                best_level = cfg_level(irq_prio[k]);
                best_num   = `IRQ_FIRST_EXC + 6'(k);
            end
        end
    end

    // ------------------------------------------------------------
    // Vector base
    // ------------------------------------------------------------
    logic base_in_range;
    logic base_aligned;
    logic base_ok;
    assign base_in_range = vector_base_offset_reg >= `VTOR_MIN &&
                           vector_base_offset_reg <= `VTOR_MAX;
    assign base_aligned  = (vector_base_offset_reg & `VTOR_ALIGN_MASK) == 32'h0000_0000;
    assign base_ok       = base_in_range && base_aligned;

    // Refusal pulses for one cycle; the base keeps its old value
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            vector_base_reject <= 1'b0;
        else
            vector_base_reject <= vector_base_write && !(privileged && base_ok);
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            vector_base <= `VTOR_RESET;
        else if (vector_base_write && privileged && base_ok)
            vector_base <= vector_base_offset_reg;
    end

    // ------------------------------------------------------------
    // Boot fetch sequence
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            boot_state <= exc_prio_pkg::ST_FETCH_SP;
        else
            case (boot_state)
                exc_prio_pkg::ST_FETCH_SP:
                    if (boot_fetch_done)
                        boot_state <= exc_prio_pkg::ST_FETCH_RV;
                exc_prio_pkg::ST_FETCH_RV:
                    if (boot_fetch_done)
                        boot_state <= exc_prio_pkg::ST_RUN;
                exc_prio_pkg::ST_RUN:
                    boot_state <= exc_prio_pkg::ST_RUN;
                default:
                    boot_state <= exc_prio_pkg::ST_FETCH_SP;
            endcase
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            boot_fetch_valid <= 1'b0;
        else
            boot_fetch_valid <= boot_state != exc_prio_pkg::ST_RUN &&
                                !(boot_state == exc_prio_pkg::ST_FETCH_RV && boot_fetch_done);
    end

    // Stack top first, then reset vector, both relative to the live base
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            boot_fetch_addr <= `OFS_STACK_TOP;
        else if (boot_state == exc_prio_pkg::ST_FETCH_SP && !boot_fetch_done)
            boot_fetch_addr <= vector_base + `OFS_STACK_TOP;
        else
            boot_fetch_addr <= vec_addr(vector_base, `EXC_RESET);
    end

    // ------------------------------------------------------------
    // Active handler and preemption
    // ------------------------------------------------------------
    // Single nesting level tracked; stacking of outer handlers is the core's job
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            active_level  <= `LVL_IDLE;
            active_number <= `EXC_NONE;
        end
        else if (exc_taken && exc_valid)
        begin
            active_level  <= best_level;
            active_number <= best_num;
        end
        else if (exc_return)
        begin
            active_level  <= `LVL_IDLE;
            active_number <= `EXC_NONE;
        end
    end

    // Winner beats the running handler; an equal level never counts
    logic outranks;
    assign outranks = best_level < active_level;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            exc_valid   <= 1'b0;
            exc_preempt <= 1'b0;
        end
        else
        begin
            // Equal level keeps waiting as pending
            exc_valid   <= boot_state == exc_prio_pkg::ST_RUN &&
                           outranks && !exc_taken;
            exc_preempt <= outranks &&
                           active_level != `LVL_IDLE;
        end
    end

    // Payload follows the winner every cycle; only meaningful with the offer flag
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            exc_number      <= `EXC_NONE;
            exc_vector_addr <= `VTOR_RESET;
        end
        else
        begin
            exc_number      <= best_num;
            exc_vector_addr <= vec_addr(vector_base, best_num);
        end
    end

endmodule
`default_nettype wire

// ### testbench/epv_asserts.sv
// Port assertions for the exception priority block
`timescale 1ns/10ps
`default_nettype none
`include "exc_prio_cfg.svh"
module epv_asserts
(
    // Clock, reset, requests
    input wire logic                  core_clk,
    input wire logic                  arst_n,
    input wire logic                  nmi_req,
    input wire logic                  hardfault_req,
    input wire logic [31:0]           vector_base_offset_reg,
    input wire logic                  vector_base_write,
    input wire logic                  privileged,
    // Results
    input wire logic                  boot_fetch_valid,
    input wire logic [31:0]           boot_fetch_addr,
    input wire logic                  exc_valid,
    input wire logic                  exc_preempt,
    input wire logic [`EXC_NUM_W-1:0] exc_number,
    input wire logic [31:0]           exc_vector_addr,
    input wire logic [`EXC_NUM_W-1:0] active_number,
    input wire logic [31:0]           vector_base,
    input wire logic                  vector_base_reject
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic bad;
    assign bad = !privileged || (vector_base_offset_reg & `VTOR_ALIGN_MASK) != 32'h0
        || vector_base_offset_reg < `VTOR_MIN || vector_base_offset_reg > `VTOR_MAX;
    sequence bad_write;
        vector_base_write && bad;
    endsequence
    sequence good_write;
        vector_base_write && !bad;
    endsequence
    vec_addr_a: assert property (
        exc_valid |-> exc_vector_addr == vector_base + {exc_number, 2'b00})
        else $error("vector address off");
    rsvd_irq_a: assert property (
        exc_valid |-> !(exc_number == 6'h19 || (exc_number > 6'h1D && exc_number < 6'h22)))
        else $error("reserved interrupt offered");
    boot_start_a: assert property (
        boot_fetch_valid && !$past(boot_fetch_valid) |-> boot_fetch_addr == `OFS_STACK_TOP)
        else $error("boot does not start at stack top");
    boot_base_a: assert property (
        boot_fetch_valid |-> vector_base == `VTOR_RESET)
        else $error("base not zero during boot");
    base_reject_a: assert property (
        bad_write |=> vector_base_reject && $stable(vector_base))
        else $error("bad base write not refused");
    base_accept_a: assert property (
        good_write |=> !vector_base_reject && vector_base == $past(vector_base_offset_reg))
        else $error("good base write lost");
    nmi_wins_a: assert property (
        exc_valid && $past(nmi_req) |-> exc_number == `EXC_NMI)
        else $error("nmi not chosen");
    fault_wins_a: assert property (
        exc_valid && $past(hardfault_req) && !$past(nmi_req) |-> exc_number == `EXC_HARDFAULT)
        else $error("hard fault not chosen");
    preempt_flag_a: assert property (
        exc_valid && active_number != `EXC_NONE |-> exc_preempt)
        else $error("preempt flag missing");
endmodule
bind exception_priority_vector epv_asserts epv_asserts_inst (.core_clk, .arst_n, .nmi_req,
    .hardfault_req, .vector_base_offset_reg, .vector_base_write, .privileged,
    .boot_fetch_valid, .boot_fetch_addr, .exc_valid, .exc_preempt, .exc_number,
    .exc_vector_addr, .active_number, .vector_base, .vector_base_reject);
`default_nettype wire

// ### testbench/core_model.sv
// Behavioural core: answers boot fetches and takes offered exceptions
`timescale 1ns/10ps
`default_nettype none
module core_model
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic arst_n,
    // From the block
    input  wire logic boot_fetch_valid,
    input  wire logic exc_valid,
    // To the block
    output var logic  boot_fetch_done,
    output var logic  exc_taken
);
    always_ff @(negedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            boot_fetch_done <= 1'b0;
            exc_taken <= 1'b0;
        end
        else
        begin
            // One pulse per offer, never two in a row
            boot_fetch_done <= boot_fetch_valid && !boot_fetch_done;
            exc_taken <= exc_valid && !exc_taken;
        end
    end
endmodule
`default_nettype wire

// ### testbench/tb_exception_priority_vector.sv
// Testbench for the exception priority block
`timescale 1ns/10ps
`default_nettype none
`include "exc_prio_cfg.svh"
module tb_exception_priority_vector;
    logic core_clk, arst_n, nmi_req, hardfault_req, memfault_req, busfault_req;
    logic usagefault_req, svcall_req, debugmon_req, pendable_service_request, systick_req;
    logic priority_write, vector_base_write, privileged, boot_fetch_done, exc_taken;
    logic exc_return, boot_fetch_valid, exc_valid, exc_preempt, vector_base_reject;
    logic [`IRQ_COUNT-1:0] irq_req, irq_enable;
    logic [3*`IRQ_COUNT-1:0] irq_priority_regs;
    logic [20:0] system_handler_priority_reg;
    logic [31:0] vector_base_offset_reg, boot_fetch_addr, exc_vector_addr, vector_base;
    logic [5:0] exc_number, active_number;
    int fails, n_tests;
    logic [31:0] base_model;
    exception_priority_vector exception_priority_vector_inst
    (
        .core_clk, .arst_n, .nmi_req, .hardfault_req, .memfault_req, .busfault_req,
        .usagefault_req, .svcall_req, .debugmon_req, .pendable_service_request,
        .systick_req, .irq_req, .irq_enable, .irq_priority_regs,
        .system_handler_priority_reg, .priority_write, .vector_base_offset_reg,
        .vector_base_write, .privileged, .boot_fetch_done, .exc_taken, .exc_return,
        .boot_fetch_valid, .boot_fetch_addr, .exc_valid, .exc_preempt, .exc_number,
        .exc_vector_addr, .active_number, .vector_base, .vector_base_reject
    );
    core_model core_model_inst
    (
        .core_clk, .arst_n, .boot_fetch_valid, .exc_valid, .boot_fetch_done, .exc_taken
    );
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Whole run is a little over a hundred cycles
    initial
    begin
        #20000;
        fails++;
        wrap_up();
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic do_reset();
        arst_n = 1'b0;
        base_model = `VTOR_RESET;
        repeat (5) @(negedge core_clk);
        arst_n = 1'b1;
        @(negedge core_clk);
        check(boot_fetch_valid, 1'b1);
        check(boot_fetch_addr, `OFS_STACK_TOP);
        @(negedge core_clk);
        check(boot_fetch_addr, 32'h0000_0004);
        repeat (5) @(negedge core_clk);
        check(boot_fetch_valid, 1'b0);
        check(vector_base, `VTOR_RESET);
    endtask
    // Waits for an offer, checks it, lets the core take it
    task automatic take(input logic [5:0] n, input logic [31:0] ofs, input logic p);
        int k;
        k = 0;
        while (exc_valid !== 1'b1 && k < 20)
        begin
            @(negedge core_clk);
            k++;
        end
        check(exc_valid, 1'b1);
        check(exc_number, n);
        check(exc_vector_addr, base_model + ofs);
        check(exc_vector_addr[1:0], 2'h0);
        check(exc_preempt, p);
        @(negedge core_clk);
        check(active_number, n);
    endtask
    task automatic quiet();
        repeat (3)
        begin
            @(negedge core_clk);
            check(exc_valid, 1'b0);
        end
    endtask
    task automatic ret();
        exc_return = 1'b1;
        @(negedge core_clk);
        exc_return = 1'b0;
    endtask
    task automatic wr(input logic [31:0] v, input logic pr, input logic rej);
        // A cycle passes first so back-to-back calls never retoggle the strobe
        @(negedge core_clk);
        vector_base_offset_reg = v;
        privileged = pr;
        vector_base_write = 1'b1;
        @(negedge core_clk);
        vector_base_write = 1'b0;
        if (!rej)
            base_model = v;
        check(vector_base_reject, rej);
        check(vector_base, base_model);
    endtask
    task automatic t_sys();
        logic [4:0] pend;
        logic [5:0] nums [5];
        logic [31:0] ofs [5];
        nums = '{`EXC_MEMFAULT, `EXC_BUSFAULT, `EXC_USAGEFAULT, `EXC_SVCALL, `EXC_DEBUGMON};
        ofs = '{32'h10, 32'h14, 32'h18, 32'h2C, 32'h30};
        pend = 5'h1F;
        {debugmon_req, svcall_req, usagefault_req, busfault_req, memfault_req} = pend;
        for (int k = 0; k < 5; k++)
        begin
            take(nums[k], ofs[k], 1'b0);
            pend[k] = 1'b0;
            {debugmon_req, svcall_req, usagefault_req, busfault_req, memfault_req} = pend;
            ret();
        end
    endtask
    task automatic t_defaults();
        pendable_service_request = 1'b1;
        systick_req = 1'b1;
        irq_req[1:0] = 2'h3;
        take(`EXC_PEND_SERVICE, `OFS_PEND_SERVICE, 1'b0);
        pendable_service_request = 1'b0;
        quiet();
        ret();
        take(`EXC_SYSTICK, `OFS_SYSTICK, 1'b0);
        systick_req = 1'b0;
        ret();
        take(`IRQ_FIRST_EXC, `OFS_IRQ_BASE, 1'b0);
        irq_req[0] = 1'b0;
        ret();
        take(6'h11, 32'h44, 1'b0);
        irq_req[1] = 1'b0;
        ret();
    endtask
    task automatic t_prio();
        irq_priority_regs[8:0] = 9'h155;
        system_handler_priority_reg[20:18] = 3'h7;
        priority_write = 1'b1;
        @(negedge core_clk);
        priority_write = 1'b0;
        irq_req[0] = 1'b1;
        take(6'h10, 32'h40, 1'b0);
        irq_req[2] = 1'b1;
        quiet();
        irq_req[1] = 1'b1;
        take(6'h11, 32'h44, 1'b1);
        irq_req[1] = 1'b0;
        ret();
        take(6'h10, 32'h40, 1'b0);
        irq_req[0] = 1'b0;
        systick_req = 1'b1;
        ret();
        take(6'h12, 32'h48, 1'b0);
        irq_req[2] = 1'b0;
        ret();
        take(`EXC_SYSTICK, `OFS_SYSTICK, 1'b0);
        systick_req = 1'b0;
        ret();
    endtask
    task automatic t_nmi();
        irq_req[1] = 1'b1;
        take(6'h11, 32'h44, 1'b0);
        irq_enable = '0;
        nmi_req = 1'b1;
        hardfault_req = 1'b1;
        take(`EXC_NMI, 32'h08, 1'b1);
        nmi_req = 1'b0;
        quiet();
        ret();
        take(`EXC_HARDFAULT, 32'h0C, 1'b0);
        hardfault_req = 1'b0;
        irq_req[1] = 1'b0;
        irq_enable = '1;
        ret();
    endtask
    task automatic t_base();
        irq_req[9] = 1'b1;
        quiet();
        irq_req[9] = 1'b0;
        wr(32'h0000_0180, 1'b1, 1'b1);
        wr(32'h0000_0000, 1'b1, 1'b1);
        wr(32'h4000_0000, 1'b1, 1'b1);
        wr(32'h0000_0200, 1'b0, 1'b1);
        wr(`VTOR_MIN, 1'b1, 1'b0);
        wr(`VTOR_MAX, 1'b1, 1'b0);
        irq_req[29] = 1'b1;
        take(6'h2D, 32'hB4, 1'b0);
        irq_req[29] = 1'b0;
        ret();
        do_reset();
    endtask
    initial
    begin
        {nmi_req, hardfault_req, memfault_req, busfault_req, usagefault_req} = '0;
        {svcall_req, debugmon_req, pendable_service_request, systick_req} = '0;
        {priority_write, vector_base_write, exc_return, arst_n} = '0;
        privileged = 1'b1;
        irq_req = '0;
        irq_enable = '1;
        irq_priority_regs = '0;
        system_handler_priority_reg = '0;
        vector_base_offset_reg = '0;
        fails = 0;
        n_tests = 0;
        do_reset();
        t_defaults();
        t_prio();
        t_sys();
        t_nmi();
        t_base();
        wrap_up();
    end
endmodule
`default_nettype wire
